// ==== logic/tlvic_defs.svh ====
// register offsets, field positions, reset values and cycle counts
// assumes: included by the controller package users, 32-bit AHB words
//
// What this block does
// - compare request level with running handler; acknowledge or keep pending
// - on acknowledge, load program counter with the vector address
// - one instruction always executes before a pending request is served
// - status register tracks levels so return restores the prior level
// - vectors default to level 0; exactly one may be level 1
// - level 1 preempts level 0 handlers; level 0 never preempts level 1
// - static scheduling serves the first pending level 0 vector after the one named in the lowest-priority register
// - round-robin enable bit switches level 0 arbitration to round robin
// - maskable levels act only while global enable is set; acknowledge leaves it alone
// - peripheral flags stay set until their vector is acknowledged, which clears them
// - vector base select bit picks application or boot region
// - high-priority vector is the number written to its register
// - entry takes finishing instruction plus two push cycles
// - vector jump takes three cycles, two with relative jump
// - a multicycle instruction completes before the request is served
// - requests taken in sleep add five cycles plus wake start-up
// - return takes four or five cycles, popping program counter
// - vector handling set by base select and compact-table bits
// - non-maskable requests ignore global enable and are never preempted
// - lowest-priority register names lowest vector; next one is highest
// - round robin writes last acknowledged level 0 vector to that register
// - compact table: non-maskable vector 1, level 1 vector 2, level 0 3
`ifndef TLVIC_DEFS_SVH
`define TLVIC_DEFS_SVH
// register index; byte address is four times this
`define TLVIC_IDX_CTRL     4'h0
`define TLVIC_IDX_STATUS   4'h1
`define TLVIC_IDX_LOWPRI   4'h2
`define TLVIC_IDX_HIVEC    4'h3
// control fields
`define TLVIC_CTRL_RR      0
`define TLVIC_CTRL_CVT     5
`define TLVIC_CTRL_VBS     6
// status fields
`define TLVIC_ST_L0        0
`define TLVIC_ST_L1        1
`define TLVIC_ST_NMI       7
`define TLVIC_REG_RESET    8'h00
// cycle counts
`define TLVIC_PUSH_CYC     3'h2
`define TLVIC_JMP_CYC      3'h3
`define TLVIC_RELATIVE_JUMP_INSTR_CYC     3'h2
`define TLVIC_WAKE_CYC     3'h5
`define TLVIC_RET_CYC      3'h4
`define TLVIC_RET_WIDE_CYC 3'h5
// compact table slots
`define TLVIC_CVT_NMI      8'h01
`define TLVIC_CVT_HI       8'h02
`define TLVIC_CVT_LOW      8'h03
`endif

// ==== logic/tlvic_pkg.sv ====
// types shared by the interrupt controller
// assumes: nothing beyond the defs header
package tlvic_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_WAKE, S_PUSH, S_JUMP, S_RET
  } tlvic_state_e;
  typedef enum logic [1:0] {L_LOW, L_HIGH, L_NMI} tlvic_level_e;
  typedef struct packed {
    logic vbs;
    logic compact_table_enable;
    logic rr;
  } tlvic_ctrl_s;
  typedef struct packed {
    logic nmi;
    logic hi;
    logic lo;
  } tlvic_status_s;
endpackage : tlvic_pkg

// ==== logic/tlvic.sv ====
// two-level vectored interrupt controller with AHB-Lite registers
// assumes: core pulses instruction-done and return, single clock domain
`timescale 1ns/1ps
`include "tlvic_defs.svh"
module tlvic #(
  parameter int          N         = 64,
  parameter logic [63:0] NMI_MASK  = 64'h2,
  parameter int          PCW       = 16,
  parameter logic [15:0] APP_BASE  = 16'h0200,
  parameter logic [15:0] BOOT_BASE = 16'h0000,
  parameter int          STRIDE    = 2,
  parameter bit          SMALL_MEM = 1'b0,
  parameter bit          WIDE_PC   = 1'b0
) (
  input  wire logic            MCLK_I,
  input  wire logic            RST_I,
  input  wire logic            HSEL_I,
  input  wire logic [31:0]     HADDR_I,
  input  wire logic [1:0]      HTRANS_I,
  input  wire logic            HWRITE_I,
  input  wire logic [2:0]      HSIZE_I,
  input  wire logic [31:0]     HWDATA_I,
  input  wire logic            HREADY_I,
  output logic      [31:0]     HRDATA_O,
  output logic                 HREADYOUT_O,
  output logic                 HRESP_O,
  input  wire logic [N-1:0]    IRQ_I,
  input  wire logic            GIE_I,
  input  wire logic            INSTR_DONE_I,
  input  wire logic            RETURN_I,
  input  wire logic            SLEEP_I,
  input  wire logic            STARTUP_DONE_I,
  output logic                 ACK_O,
  output logic      [7:0]      ACK_VEC_O,
  output logic      [PCW-1:0]  VEC_ADDR_O,
  output logic                 PUSH_O,
  output logic                 POP_O
);
  // ****************************************************
  // elaboration checks
  // ****************************************************
  if (N < 4 || N > 64 || PCW < 8 || PCW > 16) begin : g_bad
    $error("tlvic: unsupported parameter values");
  end

  // ****************************************************
  // bus slave
  // ****************************************************
  logic        wr_pend, next_wr_pend;
  logic [3:0]  wr_idx, next_wr_idx;
  logic [31:0] rdata, next_rdata;
  logic        take;
  logic [3:0]  a_idx;
  tlvic_pkg::tlvic_ctrl_s   ctrl, next_ctrl;
  tlvic_pkg::tlvic_status_s stat, next_stat;
  logic [7:0]  lowpri, next_lowpri;
  logic [7:0]  hivec, next_hivec;

  // zero wait states; word accesses only, narrower sizes act as word
  assign take        = HSEL_I && HREADY_I && HTRANS_I[1];
  assign a_idx       = HADDR_I[5:2];
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata;

  always_comb begin
    next_wr_pend = take && HWRITE_I && (HADDR_I[31:6] == 26'h0);
    next_wr_idx  = take ? a_idx : wr_idx;
    next_rdata   = rdata;
    if (take && !HWRITE_I) begin
      next_rdata = 32'h0;
      if (HADDR_I[31:6] != 26'h0) begin
        next_rdata = 32'h0;
      end else if (a_idx == `TLVIC_IDX_CTRL) begin
        next_rdata[`TLVIC_CTRL_VBS] = ctrl.vbs;
        next_rdata[`TLVIC_CTRL_CVT] = ctrl.compact_table_enable;
        next_rdata[`TLVIC_CTRL_RR]  = ctrl.rr;
      end else if (a_idx == `TLVIC_IDX_STATUS) begin
        next_rdata[`TLVIC_ST_NMI] = stat.nmi;
        next_rdata[`TLVIC_ST_L1]  = stat.hi;
        next_rdata[`TLVIC_ST_L0]  = stat.lo;
      end else if (a_idx == `TLVIC_IDX_LOWPRI) begin
        next_rdata[7:0] = lowpri;
      end else if (a_idx == `TLVIC_IDX_HIVEC) begin
        next_rdata[7:0] = hivec;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      wr_pend <= 1'b0;
      wr_idx  <= 4'h0;
      rdata   <= 32'h0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx  <= next_wr_idx;
      rdata   <= next_rdata;
    end
  end

  // ****************************************************
  // arbitration
  // ****************************************************
  tlvic_pkg::tlvic_state_e st, next_st;
  logic [N-1:0] nmi_req, hi_req, low_req, hi_bit;
  logic [8:0]   nmi_pick, low_pick;
  logic         hi_ok, take_nmi, take_hi, take_low, go;
  logic         need_instr, next_need_instr;

  function automatic logic [8:0] pick(input logic [N-1:0] r,
                                      input logic [7:0]   p);
    logic [8:0] res;
    int         k;
    res = 9'h0;
    for (int i = N; i >= 1; i--) begin
      k = (int'(p) + i) % N;
      if (r[k]) begin
        res = {1'b1, 8'(k)};
      end
    end
    return res;
  endfunction : pick

  assign hi_ok   = (hivec != 8'h0) && (int'(hivec) < N) &&
                   !NMI_MASK[hivec[5:0]];
  assign hi_bit  = hi_ok ? (N'(1) << hivec) : '0;
  assign nmi_req = IRQ_I & NMI_MASK[N-1:0];
  // promoted vector taken from its register
  assign hi_req  = IRQ_I & hi_bit;
  // vector 0 is reset and never scheduled
  assign low_req = IRQ_I & ~NMI_MASK[N-1:0] & ~hi_bit & ~N'(1);
  assign nmi_pick = pick(nmi_req, 8'(N - 1));
  assign low_pick = pick(low_req, lowpri);

  assign take_nmi = nmi_pick[8] && !stat.nmi;
  // level 1 preempts level 0 only
  assign take_hi  = !take_nmi && GIE_I && (|hi_req) &&
                    !stat.nmi && !stat.hi;
  // level 0 waits for any running handler
  assign take_low = !take_nmi && !take_hi && GIE_I && low_pick[8] &&
                    !stat.nmi && !stat.hi && !stat.lo;
  // serve only at an instruction boundary
  assign go = (take_nmi || take_hi || take_low) && !need_instr &&
              (SLEEP_I || INSTR_DONE_I);

  // ****************************************************
  // entry and return sequencer
  // ****************************************************
  logic [2:0]  cnt, next_cnt;
  logic [7:0]  vec, next_vec;
  tlvic_pkg::tlvic_level_e lvl, next_lvl;
  logic        ack, next_ack;
  logic [PCW-1:0] vaddr, next_vaddr;
  logic [7:0]  slot;
  logic [15:0] base;

  assign base = ctrl.vbs ? BOOT_BASE : APP_BASE;

  always_comb begin
    slot = vec;
    if (ctrl.compact_table_enable) begin
      case (lvl)
        tlvic_pkg::L_NMI:  slot = `TLVIC_CVT_NMI;
        tlvic_pkg::L_HIGH: slot = `TLVIC_CVT_HI;
        default:           slot = `TLVIC_CVT_LOW;
      endcase
    end
  end

  always_comb begin
    next_st         = st;
    next_cnt        = cnt;
    next_vec        = vec;
    next_lvl        = lvl;
    next_ack        = 1'b0;
    next_vaddr      = vaddr;
    next_need_instr = need_instr;
    if (INSTR_DONE_I) begin
      next_need_instr = 1'b0;
    end
    case (st)
      tlvic_pkg::S_IDLE: begin
        if (RETURN_I) begin
          next_st  = tlvic_pkg::S_RET;
          next_cnt = WIDE_PC ? `TLVIC_RET_WIDE_CYC : `TLVIC_RET_CYC;
        end else if (go) begin
          next_vec = take_nmi ? nmi_pick[7:0] :
                     take_hi  ? hivec : low_pick[7:0];
          next_lvl = take_nmi ? tlvic_pkg::L_NMI :
                     take_hi  ? tlvic_pkg::L_HIGH : tlvic_pkg::L_LOW;
          next_st  = SLEEP_I ? tlvic_pkg::S_WAKE : tlvic_pkg::S_PUSH;
          next_cnt = SLEEP_I ? `TLVIC_WAKE_CYC : `TLVIC_PUSH_CYC;
        end
      end
      tlvic_pkg::S_WAKE: begin
        if (cnt > 3'h1) begin
          next_cnt = cnt - 3'h1;
        end else if (STARTUP_DONE_I) begin
          next_st  = tlvic_pkg::S_PUSH;
          next_cnt = `TLVIC_PUSH_CYC;
        end
      end
      tlvic_pkg::S_PUSH: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_st    = tlvic_pkg::S_JUMP;
          next_cnt   = SMALL_MEM ? `TLVIC_RELATIVE_JUMP_INSTR_CYC : `TLVIC_JMP_CYC;
          next_ack   = 1'b1;
          next_vaddr = PCW'(base + 16'(slot) * 16'(STRIDE));
        end
      end
      tlvic_pkg::S_JUMP: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_st         = tlvic_pkg::S_IDLE;
          next_need_instr = 1'b1;
        end
      end
      tlvic_pkg::S_RET: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_st         = tlvic_pkg::S_IDLE;
          next_need_instr = 1'b1;
        end
      end
      default: next_st = tlvic_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st         <= tlvic_pkg::S_IDLE;
      cnt        <= 3'h0;
      vec        <= 8'h0;
      lvl        <= tlvic_pkg::L_LOW;
      ack        <= 1'b0;
      vaddr      <= '0;
      need_instr <= 1'b0;
    end else begin
      st         <= next_st;
      cnt        <= next_cnt;
      vec        <= next_vec;
      lvl        <= next_lvl;
      ack        <= next_ack;
      vaddr      <= next_vaddr;
      need_instr <= next_need_instr;
    end
  end

  assign ACK_O      = ack;
  assign ACK_VEC_O  = vec;
  assign VEC_ADDR_O = vaddr;
  assign PUSH_O     = (st == tlvic_pkg::S_PUSH);
  assign POP_O      = (st == tlvic_pkg::S_RET);

  // ****************************************************
  // register file
  // ****************************************************
  logic ret_end;
  assign ret_end = (st == tlvic_pkg::S_RET) && (cnt == 3'h1);

  always_comb begin
    next_ctrl   = ctrl;
    next_stat   = stat;
    next_lowpri = lowpri;
    next_hivec  = hivec;
    if (wr_pend) begin
      if (wr_idx == `TLVIC_IDX_CTRL) begin
        next_ctrl.vbs = HWDATA_I[`TLVIC_CTRL_VBS];
        next_ctrl.compact_table_enable = HWDATA_I[`TLVIC_CTRL_CVT];
        next_ctrl.rr  = HWDATA_I[`TLVIC_CTRL_RR];
      end else if (wr_idx == `TLVIC_IDX_LOWPRI) begin
        next_lowpri = HWDATA_I[7:0];
      end else if (wr_idx == `TLVIC_IDX_HIVEC) begin
        next_hivec = HWDATA_I[7:0];
      end
    end
    if (ack && lvl == tlvic_pkg::L_LOW && ctrl.rr) begin
      next_lowpri = vec;
    end
    if (ret_end) begin
      if (stat.nmi) begin
        next_stat.nmi = 1'b0;
      end else if (stat.hi) begin
        next_stat.hi = 1'b0;
      end else begin
        next_stat.lo = 1'b0;
      end
    end
    if (ack) begin
      case (lvl)
        tlvic_pkg::L_NMI:  next_stat.nmi = 1'b1;
        tlvic_pkg::L_HIGH: next_stat.hi  = 1'b1;
        default:           next_stat.lo  = 1'b1;
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ctrl   <= '0;
      stat   <= '0;
      lowpri <= `TLVIC_REG_RESET;
      hivec  <= `TLVIC_REG_RESET;
    end else begin
      ctrl   <= next_ctrl;
      stat   <= next_stat;
      lowpri <= next_lowpri;
      hivec  <= next_hivec;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  entry_push_len_a: assert property (
    ack |-> $past(st == tlvic_pkg::S_PUSH) &&
            $past(st == tlvic_pkg::S_PUSH, 2))
    else $error("entry did not push two cycles");
  gie_gate_a: assert property (
    (st == tlvic_pkg::S_IDLE && !RETURN_I && go && !take_nmi)
      |-> GIE_I ##1 st != tlvic_pkg::S_IDLE)
    else $error("maskable entry without global enable");
  hi_preempt_a: assert property (
    (ack && lvl == tlvic_pkg::L_LOW) |-> !stat.hi && !stat.nmi)
    else $error("level 0 entered over running handler");
  rr_update_a: assert property (
    (ack && lvl == tlvic_pkg::L_LOW && ctrl.rr)
      |=> lowpri == $past(vec))
    else $error("round robin register not updated");
  instr_gap_a: assert property (
    (need_instr && !INSTR_DONE_I && st == tlvic_pkg::S_IDLE)
      |=> st != tlvic_pkg::S_PUSH && st != tlvic_pkg::S_WAKE)
    else $error("entry without an executed instruction");
  ret_len_a: assert property (
    $fell(POP_O) |-> $past(POP_O, 4))
    else $error("return shorter than four cycles");
  cvt_addr_a: assert property (
    (ack && ctrl.compact_table_enable && lvl == tlvic_pkg::L_LOW)
      |-> vaddr == PCW'(base + 16'd3 * 16'(STRIDE)))
    else $error("compact level 0 vector wrong");
  jump_len_a: assert property (
    ack |-> (st == tlvic_pkg::S_JUMP)[*2])
    else $error("vector jump too short");
  status_set_a: assert property (
    (ack && lvl == tlvic_pkg::L_NMI) |=> stat.nmi ##1 stat.nmi)
    else $error("executing bit not set on entry");
  wake_len_a: assert property (
    $fell(st == tlvic_pkg::S_WAKE) |-> $past(st == tlvic_pkg::S_WAKE, 5))
    else $error("wake shorter than five cycles");

  nmi_entry_c: cover property (ack && lvl == tlvic_pkg::L_NMI);
  nest_c:      cover property (ack && lvl == tlvic_pkg::L_HIGH && stat.lo);
  rr_c:        cover property (ack && ctrl.rr ##[1:60] ack);
  sleep_c:     cover property (st == tlvic_pkg::S_WAKE ##[1:20] ack);
endmodule : tlvic

// ==== tb/tlvic_core_model.sv ====
// stand-in for the core and the peripherals behind the controller
// assumes: controller outputs registered, one clock, flags held per vector
`timescale 1ns/1ps
module tlvic_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [63:0] set_irq_i,
  input  wire logic        ret_req_i,
  input  wire logic        ack_i,
  input  wire logic [7:0]  ack_vec_i,
  input  wire logic        push_i,
  input  wire logic        pop_i,
  output logic      [63:0] irq_o,
  output logic             instr_done_o,
  output logic             return_o
);
  logic [1:0] jmp_cnt;
  logic       ret_pend;
  logic       busy;

  // no instructions retire while the core pushes, jumps or pops
  assign busy = ack_i | push_i | pop_i | (jmp_cnt != 2'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o        <= 64'h0;
      instr_done_o <= 1'b0;
      return_o     <= 1'b0;
      jmp_cnt      <= 2'h0;
      ret_pend     <= 1'b0;
    end else begin
      // flag set on event, cleared when its vector is acknowledged
      irq_o <= (irq_o | set_irq_i) &
               ~(ack_i ? (64'h1 << ack_vec_i[5:0]) : 64'h0);
      instr_done_o <= ~busy;
      jmp_cnt <= ack_i ? 2'h3 : ((jmp_cnt != 2'h0) ? jmp_cnt - 2'h1 : 2'h0);
      // returns only leave the core between instructions
      return_o <= ret_pend & ~busy & ~return_o;
      if (ret_req_i) begin
        ret_pend <= 1'b1;
      end else if (return_o) begin
        ret_pend <= 1'b0;
      end
    end
  end
endmodule : tlvic_core_model

// ==== tb/test_two_level_vectored_interrupt_ctrl.sv ====
// self-checking bench: register access, priority, timing of entry/return
// assumes: default controller parameters except those set below
`timescale 1ns/1ps
module test_two_level_vectored_interrupt_ctrl;
  localparam logic [15:0] APP  = 16'h0200;
  localparam logic [15:0] BOOT = 16'h0000;
  logic        mclk, rst, hsel, hwrite, gie, ret_req, hrdy, hresp;
  logic        ack, push, pop, idone, retp;
  logic        sleep, startup;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [63:0] irq, set_irq;
  logic [7:0]  ack_vec;
  logic [15:0] vec_addr;
  int          miscompares;
  int          samples_checked;
  int          last_wait;

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  tlvic #(.N(64), .APP_BASE(APP), .BOOT_BASE(BOOT), .STRIDE(2),
          .SMALL_MEM(1'b0), .WIDE_PC(1'b0)) DUT (
    .MCLK_I(mclk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .IRQ_I(irq), .GIE_I(gie),
    .INSTR_DONE_I(idone), .RETURN_I(retp), .SLEEP_I(sleep),
    .STARTUP_DONE_I(startup), .ACK_O(ack), .ACK_VEC_O(ack_vec),
    .VEC_ADDR_O(vec_addr), .PUSH_O(push), .POP_O(pop));

  tlvic_core_model core (
    .clk_i(mclk), .rst_i(rst), .set_irq_i(set_irq), .ret_req_i(ret_req),
    .ack_i(ack), .ack_vec_i(ack_vec), .push_i(push), .pop_i(pop),
    .irq_o(irq), .instr_done_o(idone), .return_o(retp));

  // ********************************
  // shared tasks
  // ********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hrdy !== 1'b1 && n < 100);
    // a bus that never answers counts against the run
    if (hrdy !== 1'b1) miscompares++;
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
    check({31'h0, hresp}, 32'h0);
  endtask : rdc

  task automatic raise(input logic [63:0] m);
    set_irq <= m;
    @(posedge mclk);
    set_irq <= 64'h0;
  endtask : raise

  function automatic logic [15:0] va(input logic [15:0] b, input int v);
    va = b + 16'(v * 2);
  endfunction : va

  // entry: push cycles counted until the acknowledge, then the jump
  task automatic take(input logic [7:0] v, input logic [15:0] a);
    int n;
    int p;
    n = 0;
    p = 0;
    do begin
      @(posedge mclk);
      n++;
      if (push === 1'b1) p++;
    end while (ack !== 1'b1 && n < 200);
    last_wait = n;
    check({31'h0, ack}, 32'h1);
    check(32'(p), 32'h2);
    if (v !== 8'hff) check({24'h0, ack_vec}, {24'h0, v});
    check({16'h0, vec_addr}, {16'h0, a});
    repeat (4) @(posedge mclk);
  endtask : take

  task automatic ret();
    int n;
    int p;
    ret_req <= 1'b1;
    @(posedge mclk);
    ret_req <= 1'b0;
    n = 0;
    p = 0;
    do begin
      @(posedge mclk);
      n++;
      if (pop === 1'b1) p++;
    end while ((p == 0 || pop === 1'b1) && n < 200);
    check(32'(p), 32'h4);
  endtask : ret

  task automatic quiet();
    int c;
    c = 0;
    repeat (20) begin
      @(posedge mclk);
      if (ack === 1'b1) c++;
    end
    check(32'(c), 32'h0);
  endtask : quiet

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ********************************
  // main sequence
  // ********************************
  initial begin
    miscompares = 0;
    samples_checked = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    gie = 1'b1;
    ret_req = 1'b0;
    set_irq = 64'h0;
    sleep = 1'b0;
    startup = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rdc(32'h00, 32'h0);
    rdc(32'h04, 32'h0);
    rdc(32'h08, 32'h0);
    rdc(32'h0c, 32'h0);
    wr(32'h00, 32'h61);
    rdc(32'h00, 32'h61);
    wr(32'h00, 32'h0);
    wr(32'h04, 32'hff);
    rdc(32'h04, 32'h0);
    rdc(32'h40, 32'h0);
    $display("test registers done");
    wr(32'h08, 32'h5);
    raise(64'h48);
    take(8'h06, va(APP, 6));
    check(32'(last_wait), 32'h4);
    ret();
    take(8'h03, va(APP, 3));
    ret();
    wr(32'h08, 32'h0);
    raise(64'h210);
    take(8'h04, va(APP, 4));
    ret();
    take(8'h09, va(APP, 9));
    ret();
    $display("test static order done");
    wr(32'h0c, 32'h9);
    raise(64'h20);
    take(8'h05, va(APP, 5));
    raise(64'h200);
    take(8'h09, va(APP, 9));
    rdc(32'h04, 32'h3);
    raise(64'h40);
    quiet();
    ret();
    rdc(32'h04, 32'h1);
    ret();
    take(8'h06, va(APP, 6));
    ret();
    rdc(32'h04, 32'h0);
    $display("test preemption done");
    gie <= 1'b0;
    raise(64'h80);
    quiet();
    raise(64'h2);
    take(8'h01, va(APP, 1));
    rdc(32'h04, 32'h80);
    ret();
    gie <= 1'b1;
    take(8'h07, va(APP, 7));
    ret();
    $display("test global enable done");
    wr(32'h00, 32'h1);
    raise(64'h10);
    take(8'h04, va(APP, 4));
    ret();
    rdc(32'h08, 32'h4);
    raise(64'h28);
    take(8'h05, va(APP, 5));
    ret();
    take(8'h03, va(APP, 3));
    ret();
    $display("test round robin done");
    // entry from sleep, start-up already done
    sleep <= 1'b1;
    raise(64'h100);
    take(8'h08, va(APP, 8));
    check(32'(last_wait), 32'h9);
    ret();
    // start-up held back: entry must wait for it
    startup <= 1'b0;
    raise(64'h400);
    quiet();
    startup <= 1'b1;
    take(8'h0a, va(APP, 10));
    check(32'(last_wait), 32'h4);
    ret();
    sleep <= 1'b0;
    $display("test sleep entry done");
    wr(32'h00, 32'h60);
    raise(64'h80);
    take(8'hff, va(BOOT, 3));
    $display("test compact table done");
    // reset while a handler runs and modes are set
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rdc(32'h00, 32'h0);
    rdc(32'h04, 32'h0);
    $display("test mid-run reset done");
    stop_test();
  end

  // run needs under 500 cycles; watchdog allows 10000
  initial begin
    #40000;
    miscompares++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : test_two_level_vectored_interrupt_ctrl
